// file: periph_irq_regs.sv
// Contract
// RULE_01: flags set on event regardless of enables
// RULE_02: peripheral gate required for any interrupt
// RULE_03: software clears flags before enabling
// RULE_04: pwm enable bits 7,3 read zero
// RULE_05: pwm enable bits 6..4 gate timebase
// RULE_06: pwm enable bits 2..0 gate shutdown
// RULE_07: request register one bit layout
// RULE_08: serial rx/tx flags read-only, unit driven
// RULE_09: request register two bit layout
// RULE_10: flag one means pending, writable flags clearable
// RULE_11: every bit resets to zero
// RULE_12: enable bits read/write, one allows interrupt
// RULE_13: enable two pairs with request two
// RULE_14: enable one pairs with request one
// RULE_15: request when flag, enable, both gates set
// RULE_16: event wins over same-cycle clear
module periph_irq_regs
	import periph_irq_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic [ADDR_W-1:0] awaddr_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	input wire logic wvalid_in,
	output logic wready_out,
	output logic [1:0] bresp_out,
	output logic bvalid_out,
	input wire logic bready_in,
	input wire logic [ADDR_W-1:0] araddr_in,
	input wire logic arvalid_in,
	output logic arready_out,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	output logic rvalid_out,
	input wire logic rready_in,
	input wire group_one_t events_one_in,
	input wire group_two_t events_two_in,
	input wire pwm_events_t pwm_events_in,
	output logic periph_irq_out
);

	if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
		$error("address width must be 8 to 32");
	end

	// address to register select, used by both channels
	function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] a);
		reg_sel_t s;
		s = SEL_NONE;
		case (a)
			ADDR_W'(OFF_PWM_EN): s = SEL_PWM_EN;
			ADDR_W'(OFF_FLAGS_ONE): s = SEL_FLAGS_ONE;
			ADDR_W'(OFF_FLAGS_TWO): s = SEL_FLAGS_TWO;
			ADDR_W'(OFF_EN_ONE): s = SEL_EN_ONE;
			ADDR_W'(OFF_EN_TWO): s = SEL_EN_TWO;
			ADDR_W'(OFF_CORE): s = SEL_CORE;
			ADDR_W'(OFF_PWM_FLAGS): s = SEL_PWM_FLAGS;
			ADDR_W'(OFF_PWM_CLR): s = SEL_PWM_CLR;
			default: s = SEL_NONE;
		endcase
		return s;
	endfunction

	wr_state_t wr_state_q;
	rd_state_t rd_state_q;
	logic aw_held_q, w_held_q, lane0_q, irq_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0] wbyte_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [7:0] pwm_en_q, en_one_q, en_two_q, core_q;
	logic [7:0] fl1, fl2, pwm_fl, pwm_clr, ev1_v, ev2_v, rd_byte, pend;
	wire aw_hs, w_hs, ar_hs, do_write, wr_hit, resp_done, rd_done, gates;
	reg_sel_t wr_sel, rd_sel;
	wire wr_pwm_en, wr_fl1, wr_fl2, wr_en1, wr_en2, wr_core, wr_pwm_clr;

	// write channel handshakes and commit
	assign awready_out = !aw_held_q;
	assign wready_out = !w_held_q;
	assign aw_hs = awvalid_in && awready_out;
	assign w_hs = wvalid_in && wready_out;
	assign do_write = (wr_state_q == WR_COLLECT) && aw_held_q && w_held_q;
	assign resp_done = bvalid_out && bready_in;
	assign bvalid_out = (wr_state_q == WR_RESP);
	assign bresp_out = bresp_q;
	assign wr_sel = decode_addr(awaddr_q);
	assign wr_hit = do_write && lane0_q;

	// per register write strobes
	assign wr_pwm_en = wr_hit && (wr_sel == SEL_PWM_EN);
	assign wr_fl1 = wr_hit && (wr_sel == SEL_FLAGS_ONE);
	assign wr_fl2 = wr_hit && (wr_sel == SEL_FLAGS_TWO);
	assign wr_en1 = wr_hit && (wr_sel == SEL_EN_ONE);
	assign wr_en2 = wr_hit && (wr_sel == SEL_EN_TWO);
	assign wr_core = wr_hit && (wr_sel == SEL_CORE);
	assign wr_pwm_clr = wr_hit && (wr_sel == SEL_PWM_CLR);

	// address and data holding, released after the response
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
		end else begin
			aw_held_q <= aw_hs || (aw_held_q && !resp_done);
			w_held_q <= w_hs || (w_held_q && !resp_done);
		end
	end

	// captured payloads
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			awaddr_q <= '0;
			wbyte_q <= REG_RESET;
			lane0_q <= 1'b0;
		end else begin
			if (aw_hs) awaddr_q <= awaddr_in;
			if (w_hs) wbyte_q <= wdata_in[7:0];
			if (w_hs) lane0_q <= wstrb_in[0];
		end
	end

	// write response sequencing
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			wr_state_q <= WR_COLLECT;
			bresp_q <= RESP_OKAY;
		end else begin
			case (wr_state_q)
				WR_COLLECT: begin
					if (do_write) begin
						wr_state_q <= WR_RESP;
						bresp_q <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
					end
				end
				WR_RESP: begin
					if (bready_in) wr_state_q <= WR_COLLECT;
				end
				default: wr_state_q <= WR_COLLECT;
			endcase
		end
	end

	// RULE_04 masked pwm enable write
	// RULE_12 enables read and write
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			pwm_en_q <= REG_RESET;
			en_one_q <= REG_RESET;
			en_two_q <= REG_RESET;
			core_q <= REG_RESET;
		end else begin
			if (wr_pwm_en) pwm_en_q <= wbyte_q & PWM_EN_MASK;
			if (wr_en1) en_one_q <= wbyte_q;
			if (wr_en2) en_two_q <= wbyte_q;
			if (wr_core) core_q <= wbyte_q & CORE_MASK;
		end
	end

	// RULE_01 events set flags unconditionally
	assign ev1_v = events_one_in;
	assign ev2_v = events_two_in;
	assign pwm_clr = wr_pwm_clr ? (wbyte_q & PWM_EN_MASK) : NO_MASK;

	// RULE_07 first request group
	// RULE_08 serial flags follow unit
	flag_bank #(
		.WIDTH(8),
		.WR_MASK(FLAGS_ONE_WR_MASK),
		.LEVEL_MASK(FLAGS_ONE_LEVEL_MASK)
	) u_flags_one (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.set_in(ev1_v),
		.clr_in(NO_MASK),
		.wr_en_in(wr_fl1),
		.wr_data_in(wbyte_q),
		.flags_out(fl1)
	);

	// RULE_09 second request group
	// RULE_10 writable flags clearable
	flag_bank #(
		.WIDTH(8),
		.WR_MASK(ALL_MASK),
		.LEVEL_MASK(NO_MASK)
	) u_flags_two (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.set_in(ev2_v),
		.clr_in(NO_MASK),
		.wr_en_in(wr_fl2),
		.wr_data_in(wbyte_q),
		.flags_out(fl2)
	);

	// pwm flags: read-only status, cleared by writing ones
	flag_bank #(
		.WIDTH(8),
		.WR_MASK(NO_MASK),
		.LEVEL_MASK(NO_MASK)
	) u_flags_pwm (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.set_in(pwm_layout(pwm_events_in)),
		.clr_in(pwm_clr),
		.wr_en_in(1'b0),
		.wr_data_in(NO_MASK),
		.flags_out(pwm_fl)
	);

	// read channel
	assign arready_out = (rd_state_q == RD_IDLE);
	assign ar_hs = arvalid_in && arready_out;
	assign rd_done = rvalid_out && rready_in;
	assign rvalid_out = (rd_state_q == RD_DATA);
	assign rdata_out = rdata_q;
	assign rresp_out = rresp_q;
	assign rd_sel = decode_addr(araddr_in);

	// read data select; clear register reads zero
	assign rd_byte = (rd_sel == SEL_PWM_EN) ? pwm_en_q :
		(rd_sel == SEL_FLAGS_ONE) ? fl1 :
		(rd_sel == SEL_FLAGS_TWO) ? fl2 :
		(rd_sel == SEL_EN_ONE) ? en_one_q :
		(rd_sel == SEL_EN_TWO) ? en_two_q :
		(rd_sel == SEL_CORE) ? core_q :
		(rd_sel == SEL_PWM_FLAGS) ? pwm_fl : REG_RESET;

	// read sequencing and captured answer
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			rd_state_q <= RD_IDLE;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else begin
			case (rd_state_q)
				RD_IDLE: begin
					if (ar_hs) begin
						rd_state_q <= RD_DATA;
						rdata_q <= {RDATA_PAD, rd_byte};
						rresp_q <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
					end
				end
				RD_DATA: begin
					if (rd_done) rd_state_q <= RD_IDLE;
				end
				default: rd_state_q <= RD_IDLE;
			endcase
		end
	end

	// RULE_05 timebase enables pair flags
	// RULE_06 shutdown enables pair flags
	// RULE_13 enable two pairing
	// RULE_14 enable one pairing
	assign pend = (fl1 & en_one_q) | (fl2 & en_two_q) | (pwm_fl & pwm_en_q);
	// RULE_02 peripheral gate qualifies
	assign gates = core_q[CORE_GLOBAL_BIT] && core_q[CORE_PERIPH_BIT];

	// RULE_15 registered request output
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= gates && (|pend);
		end
	end

	assign periph_irq_out = irq_q;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	flag_set_a: assert property ( // RULE_01
		(|ev2_v) |=> ((fl2 & $past(ev2_v)) == $past(ev2_v)))
		else $error("second group event did not set its flag");

	group_one_a: assert property ( // RULE_07
		events_one_in.timer1_gate_flag && !events_one_in.timer1_overflow_flag
		|=> fl1[7] && (!fl1[0] || $past(fl1[0]) || $past(wr_fl1)))
		else $error("first group layout wrong");

	group_two_a: assert property ( // RULE_09
		events_two_in.osc_fail_flag |=> fl2[7])
		else $error("oscillator fail flag not at bit 7");

	serial_level_a: assert property ( // RULE_08
		1'b1 |=> ((fl1 & FLAGS_ONE_LEVEL_MASK) == ($past(ev1_v) & FLAGS_ONE_LEVEL_MASK)))
		else $error("serial flags do not follow the unit");

	pwm_reserved_a: assert property ( // RULE_04
		wr_pwm_en && (wbyte_q == ALL_MASK) |=> (pwm_en_q == PWM_EN_MASK))
		else $error("pwm enable reserved bits took a write");

	gate_block_a: assert property ( // RULE_02
		!core_q[CORE_PERIPH_BIT] |=> !periph_irq_out)
		else $error("interrupt without peripheral gate");

	pwm_timebase_a: assert property ( // RULE_05
		gates && pwm_en_q[6] && pwm_fl[6] |=> periph_irq_out)
		else $error("pwm3 timebase did not interrupt");

	pwm_shutdown_a: assert property ( // RULE_06
		gates && (pwm_en_q[2:0] & pwm_fl[2:0]) == 3'b000 && (pend == NO_MASK)
		|=> !periph_irq_out)
		else $error("interrupt with nothing pending");

	shutdown_pair_a: assert property ( // RULE_06
		gates && ((pwm_en_q[2:0] & pwm_fl[2:0]) != 3'b000) |=> periph_irq_out)
		else $error("enabled pwm shutdown flag did not interrupt");

	pair_one_a: assert property ( // RULE_14
		gates && ((fl1 & en_one_q) != NO_MASK) |=> periph_irq_out)
		else $error("enabled first group flag did not interrupt");

	pair_two_a: assert property ( // RULE_13
		gates && ((fl2 & en_two_q) != NO_MASK) |=> periph_irq_out)
		else $error("enabled second group flag did not interrupt");

	flag_clear_a: assert property ( // RULE_10
		wr_fl2 && (wbyte_q == NO_MASK) && !(|ev2_v) |=> (fl2 == NO_MASK))
		else $error("writing zero did not clear flags");

	set_wins_a: assert property ( // RULE_16
		wr_fl2 && !wbyte_q[0] && events_two_in.capcomp2_flag |=> fl2[0])
		else $error("clear beat a same-cycle event");

	reset_zero_a: assert property ( // RULE_11
		$past(reset_in) |-> (pwm_en_q | en_one_q | en_two_q | core_q | fl2 | pwm_fl) == NO_MASK)
		else $error("register not zero after reset");

	enable_rw_a: assert property ( // RULE_12
		wr_en1 |=> (en_one_q == $past(wbyte_q)))
		else $error("enable register did not take the write");

	write_resp_c: cover property (do_write ##1 (bvalid_out && bready_in));
	read_resp_c: cover property (ar_hs ##1 rvalid_out && rready_in);
	irq_rise_c: cover property (!periph_irq_out ##1 periph_irq_out);
	collide_c: cover property (wr_fl2 && (|(ev2_v & ~wbyte_q)));

endmodule

// file: periph_irq_pkg.sv
package periph_irq_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFF_PWM_EN = 8'h00;
	localparam logic [7:0] OFF_FLAGS_ONE = 8'h04;
	localparam logic [7:0] OFF_FLAGS_TWO = 8'h08;
	localparam logic [7:0] OFF_EN_ONE = 8'h0C;
	localparam logic [7:0] OFF_EN_TWO = 8'h10;
	localparam logic [7:0] OFF_CORE = 8'h14;
	localparam logic [7:0] OFF_PWM_FLAGS = 8'h18;
	localparam logic [7:0] OFF_PWM_CLR = 8'h1C;

	// field masks and reset value
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] NO_MASK = 8'h00;
	localparam logic [7:0] ALL_MASK = 8'hFF;
	localparam logic [7:0] PWM_EN_MASK = 8'h77;
	localparam logic [7:0] FLAGS_ONE_WR_MASK = 8'hCF;
	localparam logic [7:0] FLAGS_ONE_LEVEL_MASK = 8'h30;
	localparam logic [7:0] CORE_MASK = 8'hC0;
	localparam int CORE_GLOBAL_BIT = 7;
	localparam int CORE_PERIPH_BIT = 6;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [23:0] RDATA_PAD = 24'h00_0000;

	// first request flag group, bit 7 first
	typedef struct packed {
		logic timer1_gate_flag;
		logic converter_done_flag;
		logic serial_rx_flag;
		logic serial_tx_flag;
		logic sync_serial_flag;
		logic capcomp1_flag;
		logic timer2_match_flag;
		logic timer1_overflow_flag;
	} group_one_t;

	// second request flag group, bit 7 first
	typedef struct packed {
		logic osc_fail_flag;
		logic comparator2_flag;
		logic comparator1_flag;
		logic eeprom_write_done_flag;
		logic bus_collision_flag;
		logic comparator4_flag;
		logic comparator3_flag;
		logic capcomp2_flag;
	} group_two_t;

	// switch-mode pwm unit events
	typedef struct packed {
		logic pwm3_timebase;
		logic pwm2_timebase;
		logic pwm1_timebase;
		logic pwm3_shutdown;
		logic pwm2_shutdown;
		logic pwm1_shutdown;
	} pwm_events_t;

	typedef enum logic [1:0] {
		WR_COLLECT = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} rd_state_t;

	typedef enum logic [3:0] {
		SEL_NONE, SEL_PWM_EN, SEL_FLAGS_ONE, SEL_FLAGS_TWO, SEL_EN_ONE,
		SEL_EN_TWO, SEL_CORE, SEL_PWM_FLAGS, SEL_PWM_CLR
	} reg_sel_t;

	// pwm events placed in the enable register layout
	function automatic logic [7:0] pwm_layout(input pwm_events_t p);
		pwm_layout = {1'b0, p.pwm3_timebase, p.pwm2_timebase, p.pwm1_timebase,
			1'b0, p.pwm3_shutdown, p.pwm2_shutdown, p.pwm1_shutdown};
	endfunction

endpackage

// file: flag_bank.sv
module flag_bank
	import periph_irq_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] WR_MASK = '1,
	parameter logic [WIDTH-1:0] LEVEL_MASK = '0
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] clr_in,
	input wire logic wr_en_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	output logic [WIDTH-1:0] flags_out
);

	logic [WIDTH-1:0] flags_q;
	logic [WIDTH-1:0] flags_d;

	if (WIDTH < 1) begin : g_chk
		$error("flag_bank width must be at least one");
	end

	// per bit next value: level bits follow source, others are sticky
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic keep;
		assign keep = (wr_en_in && WR_MASK[i]) ? wr_data_in[i] : (flags_q[i] & ~clr_in[i]);
		// RULE_16 event beats clear
		assign flags_d[i] = LEVEL_MASK[i] ? set_in[i] : (set_in[i] | keep);
	end

	// RULE_11 reset clears flags
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign flags_out = flags_q;

endmodule

// file: periph_irq_enable_flags_tb.sv
module periph_irq_enable_flags_tb
	import periph_irq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] awaddr_in = 8'h00;
	logic [7:0] araddr_in = 8'h00;
	logic awvalid_in = 1'b0;
	logic wvalid_in = 1'b0;
	logic bready_in = 1'b0;
	logic arvalid_in = 1'b0;
	logic rready_in = 1'b0;
	logic [31:0] wdata_in = 32'h0000_0000;
	logic [3:0] wstrb_in = 4'h0;
	group_one_t events_one_in = '0;
	group_two_t events_two_in = '0;
	pwm_events_t pwm_events_in = '0;
	wire logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, periph_irq_out;
	wire logic [1:0] bresp_out, rresp_out;
	wire logic [31:0] rdata_out;
	int mismatches = 0;
	int check_count = 0;
	logic [7:0] m;

	periph_irq_regs #(.ADDR_W(8)) i_dut (.ref_clk_in, .reset_in, .awaddr_in, .awvalid_in,
		.awready_out, .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out,
		.bready_in, .araddr_in, .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out,
		.rready_in, .events_one_in, .events_two_in, .pwm_events_in, .periph_irq_out);

	// 50 MHz clock
	initial begin
		forever #10 ref_clk_in = ~ref_clk_in;
	end

	// compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string msg);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, s, e);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// bus write; readies sampled at the negedge before the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF,
			input logic [7:0] e2 = 8'h00, input logic [1:0] er = RESP_OKAY);
		logic ta, tw, tb;
		logic [1:0] r;
		int n;
		n = 0;
		tb = 1'b0;
		awaddr_in <= a;
		awvalid_in <= 1'b1;
		wdata_in <= {24'h00_0000, d};
		wstrb_in <= s;
		wvalid_in <= 1'b1;
		bready_in <= 1'b1;
		while (!tb) begin
			@(negedge ref_clk_in);
			ta = awready_out & awvalid_in;
			tw = wready_out & wvalid_in;
			tb = bvalid_out;
			r = bresp_out;
			@(posedge ref_clk_in);
			// event lands on the commit edge, one after both are taken
			events_two_in <= (ta && tw) ? e2 : 8'h00;
			if (ta) awvalid_in <= 1'b0;
			if (tw) wvalid_in <= 1'b0;
			if (tb) bready_in <= 1'b0;
			if (++n > 100) begin
				mismatches++;
				wrap_up();
			end
		end
		chk(r, er, "bresp");
		@(posedge ref_clk_in);
	endtask

	// bus read with expected data and response
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		n = 0;
		tr = 1'b0;
		araddr_in <= a;
		arvalid_in <= 1'b1;
		rready_in <= 1'b1;
		while (!tr) begin
			@(negedge ref_clk_in);
			ta = arready_out & arvalid_in;
			tr = rvalid_out;
			d = rdata_out;
			r = rresp_out;
			@(posedge ref_clk_in);
			if (ta) arvalid_in <= 1'b0;
			if (tr) rready_in <= 1'b0;
			if (++n > 100) begin
				mismatches++;
				wrap_up();
			end
		end
		chk(d, {24'h00_0000, e}, "rdata");
		chk(r, er, "rresp");
		@(posedge ref_clk_in);
	endtask

	// one-cycle event pulse; serial levels in group one stay up
	task automatic ev(input logic [7:0] e1, input logic [7:0] e2, input pwm_events_t p);
		events_one_in <= e1;
		events_two_in <= e2;
		pwm_events_in <= p;
		@(posedge ref_clk_in);
		events_one_in <= e1 & 8'h30;
		events_two_in <= 8'h00;
		pwm_events_in <= '0;
		@(posedge ref_clk_in);
		@(posedge ref_clk_in);
	endtask

	task automatic irq_is(input logic e);
		@(negedge ref_clk_in);
		chk({31'h0, periph_irq_out}, {31'h0, e}, "irq");
		@(posedge ref_clk_in);
	endtask

	task automatic done(input string t);
		$display("test %s done at %0t", t, $time);
	endtask

	// main sequence
	initial begin
		repeat (12) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		@(posedge ref_clk_in);
		for (int i = 0; i < 8; i++) rd(8'(4 * i), 8'h00);
		done("reset");
		wr(OFF_PWM_EN, 8'hFF);
		rd(OFF_PWM_EN, 8'h77);
		wr(OFF_PWM_EN, 8'h00);
		rd(OFF_PWM_EN, 8'h00);
		wr(OFF_FLAGS_ONE, 8'hFF);
		rd(OFF_FLAGS_ONE, 8'hCF);
		wr(OFF_FLAGS_ONE, 8'h00);
		ev(8'h30, 8'h00, '0);
		wr(OFF_FLAGS_ONE, 8'h00);
		rd(OFF_FLAGS_ONE, 8'h30);
		ev(8'h00, 8'h00, '0);
		rd(OFF_FLAGS_ONE, 8'h00);
		done("access");
		// each source sets only its own flag, enables all off
		for (int i = 0; i < 8; i++) begin
			m = 8'(1 << i);
			ev(m, m, '0);
			rd(OFF_FLAGS_ONE, m);
			rd(OFF_FLAGS_TWO, m);
			irq_is(1'b0);
			wr(OFF_FLAGS_ONE, 8'h00);
			wr(OFF_FLAGS_TWO, 8'h00);
		end
		done("layout");
		wr(OFF_EN_TWO, 8'h01);
		wr(OFF_CORE, 8'hC0);
		rd(OFF_CORE, 8'hC0);
		irq_is(1'b0);
		ev(8'h00, 8'h01, '0);
		irq_is(1'b1);
		wr(OFF_CORE, 8'h80);
		irq_is(1'b0);
		wr(OFF_CORE, 8'h40);
		irq_is(1'b0);
		wr(OFF_CORE, 8'hC0);
		irq_is(1'b1);
		wr(OFF_FLAGS_TWO, 8'h00);
		irq_is(1'b0);
		wr(OFF_FLAGS_TWO, 8'h00, 4'hF, 8'h01);
		rd(OFF_FLAGS_TWO, 8'h01);
		wr(OFF_FLAGS_TWO, 8'h00);
		wr(OFF_EN_TWO, 8'h00);
		wr(OFF_EN_ONE, 8'h80);
		ev(8'h80, 8'h00, '0);
		irq_is(1'b1);
		wr(OFF_EN_ONE, 8'h00);
		irq_is(1'b0);
		wr(OFF_FLAGS_ONE, 8'h00);
		done("interrupt");
		// pwm sources, enable then clear
		for (int j = 0; j < 6; j++) begin
			m = (j < 3) ? 8'(1 << j) : 8'(1 << (j + 1));
			ev(8'h00, 8'h00, pwm_events_t'(6'(1 << j)));
			rd(OFF_PWM_FLAGS, m);
			irq_is(1'b0);
			wr(OFF_PWM_EN, m);
			irq_is(1'b1);
			wr(OFF_PWM_CLR, m);
			rd(OFF_PWM_FLAGS, 8'h00);
			irq_is(1'b0);
			wr(OFF_PWM_EN, 8'h00);
		end
		done("pwm");
		wr(OFF_EN_ONE, 8'hFF, 4'hE);
		rd(OFF_EN_ONE, 8'h00);
		wr(8'h20, 8'hFF, 4'hF, 8'h00, RESP_SLVERR);
		rd(8'h20, 8'h00, RESP_SLVERR);
		rd(8'h02, 8'h00, RESP_SLVERR);
		done("errors");
		// reset in mid-run clears everything again
		wr(OFF_EN_TWO, 8'hFF);
		ev(8'h00, 8'hFF, '0);
		reset_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		@(posedge ref_clk_in);
		rd(OFF_EN_TWO, 8'h00);
		rd(OFF_FLAGS_TWO, 8'h00);
		irq_is(1'b0);
		done("second reset");
		wrap_up();
	end
endmodule
